// >>> design/ioac_consts.svh
// Constants of the I/O station autoconfiguration engine: offsets, field
// positions, reset values and default module settings.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef IOAC_CONSTS_SVH
`define IOAC_CONSTS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define IOAC_OFS_CTRL      12'h000
`define IOAC_OFS_CMD       12'h004
`define IOAC_OFS_STATUS    12'h008
`define IOAC_OFS_FAULT     12'h00C
`define IOAC_OFS_MAN_DATA  12'h010
`define IOAC_OFS_MAN_SLOT  12'h014
`define IOAC_OFS_NEXT_REF  12'h018
`define IOAC_OFS_AI_SCALE  12'h028
`define IOAC_OFS_SLOT_TBL  12'h040

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define IOAC_CTRL_AUTO     0
`define IOAC_CTRL_PROT     1
`define IOAC_CMD_TOGGLE    0
`define IOAC_CMD_CONFIRM   1
`define IOAC_CMD_CANCEL    2
`define IOAC_CMD_MANUAL    3
`define IOAC_FLT_ADD       0
`define IOAC_FLT_LOSS      1
`define IOAC_FLT_MISMATCH  2
`define IOAC_FLT_EXTRA     3

// Slot entry: [0] valid [2:1] type [7:3] points [23:8] base reference
// [24] report faults [25] hold last state [26] channel active
// [28:27] range [29] output default
`define IOAC_E_VALID       0
`define IOAC_E_TYPE_LO     1
`define IOAC_E_PTS_LO      3
`define IOAC_E_BASE_LO     8
`define IOAC_E_REPORT      24
`define IOAC_E_HOLD        25
`define IOAC_E_ACTIVE      26
`define IOAC_E_RANGE_LO    27
`define IOAC_E_OUTDEF      29

// ------------------------------------------------------------
// Reset values and defaults
// ------------------------------------------------------------
`define IOAC_AUTO_RST      1'b1
`define IOAC_PROT_RST      1'b0
`define IOAC_REF_FIRST     16'h0001
`define IOAC_RANGE_0_20MA  2'h1
`define IOAC_SCALE_LOW     16'h0000
`define IOAC_SCALE_HIGH    16'h4E20
`define IOAC_ALARM_LOW     16'h0000
`define IOAC_LAST_SLOT     3'h7

`endif

// >>> design/ioac_pkg.sv
// Types shared by the autoconfiguration engine.
// Assumes nothing beyond a SystemVerilog compiler.
package ioac_pkg;

  typedef enum logic [1:0]
  {
    IOAC_DISC_IN,
    IOAC_DISC_OUT,
    IOAC_ANA_IN,
    IOAC_ANA_OUT
  } ioac_mtype_t;

  typedef enum logic [2:0]
  {
    IOAC_IDLE,
    IOAC_QUERY,
    IOAC_EVAL,
    IOAC_RELEASE
  } ioac_state_t;

endpackage

// >>> design/ioac_sync.sv
// Two-flop synchroniser for a group of slot-side pin levels.
// Assumes the far side holds data stable while its acknowledge is high.
`timescale 1ns/1ns
`default_nettype none
module ioac_sync
#(
  parameter int W = 1
)
(
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> design/ioac_cfg_store.sv
// Eight-entry slot configuration store with registered read data.
// Assumes one writer per cycle; erase clears every valid flag at once.
`timescale 1ns/1ns
`default_nettype none
`include "ioac_consts.svh"
module ioac_cfg_store
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        we,
  input  wire logic [2:0]  waddr,
  input  wire logic [31:0] wdata,
  input  wire logic        erase,
  input  wire logic [2:0]  raddr,
  output logic      [31:0] rdata
);
  logic [31:0] mem [8];
  logic [7:0]  valid;

  // Data words carry no reset; only the valid flags need a known state
  always_ff @(posedge mclk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      valid <= 8'h00;
    else if (erase)
      valid <= 8'h00;
    else if (we)
      valid[waddr] <= wdata[`IOAC_E_VALID];
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      rdata <= 32'h0000_0000;
    else if (valid[raddr])
      rdata <= mem[raddr];
    else
      rdata <= 32'h0000_0000;
  end
endmodule
`default_nettype wire

// >>> design/ioac_autoconfig.sv
// Autoconfiguration engine: scans module slots, allocates references,
// records default settings in the configuration store, logs faults.
// Assumes an APB master on mclk and slot modules answering a four-phase
// request/acknowledge query on asynchronous pins.
`timescale 1ns/1ns
`default_nettype none
`include "ioac_consts.svh"
module ioac_autoconfig
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             slot_req,
  output logic      [2:0]  slot_sel,
  input  wire logic        slot_ack,
  input  wire logic        slot_present,
  input  wire logic [1:0]  slot_type,
  input  wire logic [4:0]  slot_points,
  output logic             pass_done,
  output logic             confirm_req
);
  import ioac_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  ioac_state_t state;
  logic        auto_en;
  logic        protect;
  logic        pwrup_pend;
  logic        alloc_stop;
  logic        erase_pend;
  logic [3:0]  fault;
  logic [31:0] man_data;
  logic [2:0]  man_slot;
  logic [15:0] next_ref [4];
  logic [8:0]  pins_s;
  logic        ack_s;
  logic        cap_present;
  logic [1:0]  cap_type;
  logic [4:0]  cap_pts;
  logic [31:0] rd_entry;
  logic        acc;
  logic        wr_acc;
  logic        cmd_wr;
  logic        do_toggle;
  logic        do_confirm;
  logic        do_cancel;
  logic        man_ok;
  logic        start_req;
  logic        start_ok;
  logic        busy;
  logic        ent_valid;
  logic [1:0]  ent_type;
  logic        add_new;
  logic [3:0]  flt_set;
  logic        mem_we;
  logic [2:0]  mem_waddr;
  logic [31:0] mem_wdata;
  logic [31:0] new_entry;
  logic [2:0]  mem_raddr;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        tbl_hit;

  // ------------------------------------------------------------
  // Slot pin synchronisers
  // ------------------------------------------------------------
  ioac_sync #(.W(9)) u_pin_sync
  (
    .mclk   (mclk),
    .resetn (resetn),
    .d      ({slot_ack, slot_present, slot_type, slot_points}),
    .q      (pins_s)
  );

  assign ack_s = pins_s[8];

  // ------------------------------------------------------------
  // Configuration store
  // ------------------------------------------------------------
  assign busy      = (state != IOAC_IDLE);
  assign mem_raddr = busy ? slot_sel : paddr[4:2];

  ioac_cfg_store u_store
  (
    .mclk   (mclk),
    .resetn (resetn),
    .we     (mem_we),
    .waddr  (mem_waddr),
    .wdata  (mem_wdata),
    .erase  (start_ok && erase_pend),
    .raddr  (mem_raddr),
    .rdata  (rd_entry)
  );

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  assign acc        = psel && penable && pready;
  assign wr_acc     = acc && pwrite;
  assign cmd_wr     = wr_acc && (paddr == `IOAC_OFS_CMD);
  assign do_toggle  = cmd_wr && pwdata[`IOAC_CMD_TOGGLE] && !protect;
  assign do_confirm = cmd_wr && pwdata[`IOAC_CMD_CONFIRM] && confirm_req;
  assign do_cancel  = cmd_wr && pwdata[`IOAC_CMD_CANCEL] && confirm_req;
  // Manual writes during a pass would race the scan, so they are dropped
  assign man_ok     = cmd_wr && pwdata[`IOAC_CMD_MANUAL] && !protect && !busy;
  assign start_req  = !busy && (pwrup_pend || erase_pend);
  assign start_ok   = start_req && !protect;

  // ------------------------------------------------------------
  // Enable, protection and confirmation
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      auto_en     <= `IOAC_AUTO_RST;
      confirm_req <= 1'b0;
    end
    else
    begin
      if (man_ok)
        auto_en <= 1'b0;
      else if (do_toggle)
        auto_en <= !auto_en;
      if (do_toggle && !auto_en)
        confirm_req <= 1'b1;
      else if (do_confirm || do_cancel || (do_toggle && auto_en))
        confirm_req <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      protect <= `IOAC_PROT_RST;
    else if (wr_acc && paddr == `IOAC_OFS_CTRL)
      protect <= pwdata[`IOAC_CTRL_PROT];
  end

  // Pass requests: one after reset, one per confirm
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pwrup_pend <= 1'b1;
      erase_pend <= 1'b0;
    end
    else
    begin
      if (start_req)
        pwrup_pend <= 1'b0;
      if (do_confirm)
        erase_pend <= 1'b1;
      else if (start_req)
        erase_pend <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Manual entry registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      man_data <= 32'h0000_0000;
      man_slot <= 3'h0;
    end
    else
    begin
      if (wr_acc && paddr == `IOAC_OFS_MAN_DATA)
        man_data <= pwdata;
      if (wr_acc && paddr == `IOAC_OFS_MAN_SLOT)
        man_slot <= pwdata[2:0];
    end
  end

  // ------------------------------------------------------------
  // Scan sequencer
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state      <= IOAC_IDLE;
      slot_req   <= 1'b0;
      slot_sel   <= 3'h0;
      alloc_stop <= 1'b0;
      pass_done  <= 1'b0;
    end
    else
    begin
      pass_done <= 1'b0;
      unique case (state)
        IOAC_IDLE:
        begin
          if (start_ok && (auto_en || erase_pend))
          begin
            state      <= IOAC_QUERY;
            slot_sel   <= 3'h0;
            slot_req   <= 1'b1;
            alloc_stop <= 1'b0;
          end
          else if (start_req)
            pass_done <= 1'b1;
        end
        IOAC_QUERY:
        begin
          if (ack_s)
            state <= IOAC_EVAL;
        end
        IOAC_EVAL:
        begin
          slot_req <= 1'b0;
          state    <= IOAC_RELEASE;
          if (!cap_present)
            alloc_stop <= 1'b1;
        end
        IOAC_RELEASE:
        begin
          // Next slot only once the module has dropped its answer
          if (!ack_s)
          begin
            if (slot_sel == `IOAC_LAST_SLOT)
            begin
              state     <= IOAC_IDLE;
              pass_done <= 1'b1;
            end
            else
            begin
              slot_sel <= slot_sel + 3'h1;
              slot_req <= 1'b1;
              state    <= IOAC_QUERY;
            end
          end
        end
      endcase
    end
  end

  // Response captured as the acknowledge is seen
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cap_present <= 1'b0;
      cap_type    <= 2'h0;
      cap_pts     <= 5'h00;
    end
    else if (state == IOAC_QUERY && ack_s)
    begin
      cap_present <= pins_s[7];
      cap_type    <= pins_s[6:5];
      cap_pts     <= pins_s[4:0];
    end
  end

  // ------------------------------------------------------------
  // Allocation and defaults
  // ------------------------------------------------------------
  assign ent_valid = rd_entry[`IOAC_E_VALID];
  assign ent_type  = rd_entry[`IOAC_E_TYPE_LO +: 2];
  // A configured slot is never rewritten by a pass
  assign add_new   = (state == IOAC_EVAL) && cap_present && !ent_valid
                     && !alloc_stop;

  always_comb
  begin
    new_entry = 32'h0000_0000;
    new_entry[`IOAC_E_VALID]         = 1'b1;
    new_entry[`IOAC_E_TYPE_LO +: 2]  = cap_type;
    new_entry[`IOAC_E_PTS_LO +: 5]   = cap_pts;
    new_entry[`IOAC_E_BASE_LO +: 16] = next_ref[cap_type];
    new_entry[`IOAC_E_REPORT]        = 1'b1;
    new_entry[`IOAC_E_HOLD]          = 1'b0;
    new_entry[`IOAC_E_OUTDEF]        = 1'b0;
    if (cap_type[1])
    begin
      new_entry[`IOAC_E_ACTIVE]        = 1'b1;
      new_entry[`IOAC_E_RANGE_LO +: 2] = `IOAC_RANGE_0_20MA;
    end
  end

  assign mem_we    = add_new || man_ok;
  assign mem_waddr = man_ok ? man_slot : slot_sel;
  assign mem_wdata = man_ok ? man_data : new_entry;

  // One counter per table, indexed by module type
  generate
    for (genvar t = 0; t < 4; t++)
    begin : g_ref
      always_ff @(posedge mclk or negedge resetn)
      begin
        if (!resetn)
          next_ref[t] <= `IOAC_REF_FIRST;
        else if (start_ok)
          next_ref[t] <= `IOAC_REF_FIRST;
        else if (add_new && cap_type == 2'(t))
          next_ref[t] <= next_ref[t] + 16'(cap_pts);
        else if (state == IOAC_EVAL && cap_present && ent_valid && !alloc_stop
                 && ent_type == 2'(t) && cap_type == ent_type)
          next_ref[t] <= rd_entry[`IOAC_E_BASE_LO +: 16]
                         + 16'(rd_entry[`IOAC_E_PTS_LO +: 5]);
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Fault log, write one to clear, new events win
  // ------------------------------------------------------------
  always_comb
  begin
    flt_set = 4'h0;
    if (state == IOAC_EVAL)
    begin
      flt_set[`IOAC_FLT_ADD]      = add_new;
      flt_set[`IOAC_FLT_LOSS]     = !cap_present && ent_valid;
      flt_set[`IOAC_FLT_MISMATCH] = cap_present && ent_valid
                                    && (cap_type != ent_type);
      flt_set[`IOAC_FLT_EXTRA]    = cap_present && !ent_valid && alloc_stop;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      fault <= 4'h0;
    else if (wr_acc && paddr == `IOAC_OFS_FAULT)
      fault <= (fault & ~pwdata[3:0]) | flt_set;
    else
      fault <= fault | flt_set;
  end

  // ------------------------------------------------------------
  // APB read path, two access cycles per transfer, more for table reads during a pass
  // ------------------------------------------------------------
  assign tbl_hit = (paddr[11:5] == 7'(`IOAC_OFS_SLOT_TBL >> 5));

  always_comb
  begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (tbl_hit)
      next_prdata = rd_entry;
    else if (paddr >= `IOAC_OFS_NEXT_REF && paddr < `IOAC_OFS_AI_SCALE
             && paddr[1:0] == 2'h0)
      next_prdata = {16'h0000, next_ref[paddr[3:2] + 2'h2]};
    else
    begin
      unique case (paddr)
        `IOAC_OFS_CTRL:     next_prdata = {30'h0, protect, auto_en};
        `IOAC_OFS_CMD:      next_prdata = 32'h0000_0000;
        `IOAC_OFS_STATUS:   next_prdata = {28'h0, slot_sel, busy}
                                          | {30'h0, confirm_req, 1'b0} << 4;
        `IOAC_OFS_FAULT:    next_prdata = {28'h0, fault};
        `IOAC_OFS_MAN_DATA: next_prdata = man_data;
        `IOAC_OFS_MAN_SLOT: next_prdata = {29'h0, man_slot};
        `IOAC_OFS_AI_SCALE: next_prdata = {`IOAC_SCALE_HIGH, `IOAC_SCALE_LOW};
        default:            next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      // Table reads wait while the scan owns the store's read port, and
      // one cycle more (the pass_done cycle) so the read data turns round
      pready  <= psel && penable && !pready && !(tbl_hit && (busy || pass_done));
      prdata  <= (psel && penable && !pready && !pwrite) ? next_prdata : 32'h0;
      pslverr <= psel && penable && !pready && next_pslverr;
    end
  end
endmodule
`default_nettype wire

// >>> test/ioac_autoconfig_properties.sv
// Port checker for the autoconfiguration engine.
// Assumes it is bound onto ioac_autoconfig and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
`include "ioac_consts.svh"
module ioac_properties
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        slot_req,
  input wire logic [2:0]  slot_sel,
  input wire logic        slot_ack,
  input wire logic        slot_present,
  input wire logic [1:0]  slot_type,
  input wire logic [4:0]  slot_points,
  input wire logic        pass_done,
  input wire logic        confirm_req
);
  // Slot of the previous query, to see the scan step
  logic [2:0] prev_sel;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      prev_sel <= 3'h0;
    else if (slot_req)
      prev_sel <= slot_sel;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  done_pulse_a: assert property (pass_done |=> !pass_done)
    else $error("pass_done longer than one cycle");
  done_idle_a: assert property (pass_done |-> !slot_req)
    else $error("pass_done during a query");
  scan_step_a: assert property ($rose(slot_req) |->
    (slot_sel == 3'h0 || slot_sel == prev_sel + 3'h1))
    else $error("slot scan out of order");
  last_done_a: assert property ($fell(slot_req) && slot_sel == 3'h7
    |-> ##[1:12] pass_done)
    else $error("no pass_done after last slot");
  req_wait_a: assert property ($fell(slot_req) |->
    $past(slot_ack) && $past(slot_ack, 2))
    else $error("query released before answer");
  sel_hold_a: assert property (slot_req && $past(slot_req) |-> $stable(slot_sel))
    else $error("slot_sel moved during query");
  confirm_cause_a: assert property ($rose(confirm_req) |->
    $past(pready && pwrite && paddr == `IOAC_OFS_CMD && pwdata[`IOAC_CMD_TOGGLE]))
    else $error("confirm_req without toggle");
  ready_cause_a: assert property (pready |-> $past(psel && penable) ##1 !pready)
    else $error("pready without access");
  ready_soon_a: assert property ($rose(penable) && psel && paddr < 12'h040 |=> pready)
    else $error("register access not answered");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
endmodule
`default_nettype wire

// >>> test/ioac_slot_model.sv
// Slot modules answering the four-phase presence query.
// Assumes the bench sets each slot's module and the answer delay.
`timescale 1ns/1ns
`default_nettype none
module ioac_slot_model
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        slot_req,
  input  wire logic [2:0]  slot_sel,
  input  wire logic [7:0]  m_pres,
  input  wire logic [15:0] m_type,
  input  wire logic [39:0] m_pts,
  input  wire logic [3:0]  dly,
  output logic             slot_ack,
  output logic             slot_present,
  output logic [1:0]       slot_type,
  output logic [4:0]       slot_points
);
  logic [3:0] cnt;
  logic       tick;
  // Answer dly+1 cycles into the request, release once the request falls
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= 4'h0;
      slot_ack <= 1'b0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= !tick;
      if (slot_req && !slot_ack)
      begin
        cnt <= cnt + 4'h1;
        slot_ack <= (cnt >= dly);
      end
      else if (!slot_req)
      begin
        cnt <= 4'h0;
        slot_ack <= 1'b0;
      end
    end
  end
  // Data only valid with the answer; otherwise it keeps changing
  assign slot_present = slot_ack ? m_pres[slot_sel] : tick;
  assign slot_type = slot_ack ? m_type[2*slot_sel +: 2] : {tick, !tick};
  assign slot_points = slot_ack ? m_pts[5*slot_sel +: 5] : {5{tick}};
endmodule
`default_nettype wire

// >>> test/ioac_tb.sv
// Register-level bench for the autoconfiguration engine.
// Assumes the slot model on the query pins and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`include "ioac_consts.svh"
module tb;
  import ioac_pkg::*;
  logic mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, slot_req, slot_ack, slot_present, pass_done, confirm_req;
  logic last_err;
  logic [2:0] slot_sel;
  logic [1:0] slot_type;
  logic [4:0] slot_points;
  // Slots 0..7: AI8 DO8 DO16 AO4 DI16 DO8 DI16 AO4
  logic [7:0] m_pres = 8'hFF;
  logic [15:0] m_type = 16'hC4D6;
  logic [39:0] m_pts = 40'h2411024108;
  logic [3:0] dly = 4'h0;
  int bad_count = 0, n_tests = 0;
  always #2 mclk = !mclk;
  ioac_autoconfig uut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slot_req(slot_req), .slot_sel(slot_sel), .slot_ack(slot_ack),
    .slot_present(slot_present), .slot_type(slot_type), .slot_points(slot_points),
    .pass_done(pass_done), .confirm_req(confirm_req));
  ioac_slot_model u_slots (.mclk(mclk), .resetn(resetn), .slot_req(slot_req),
    .slot_sel(slot_sel), .m_pres(m_pres), .m_type(m_type), .m_pts(m_pts), .dly(dly),
    .slot_ack(slot_ack), .slot_present(slot_present), .slot_type(slot_type),
    .slot_points(slot_points));
  task automatic close_out();
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge mclk);
      i++;
    end
    while (pready !== 1'b1 && i < 3000);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let the accepting edge's updates settle before callers look
    #1;
    if (i >= 3000)
    begin
      bad_count++;
      close_out();
    end
  endtask
  task automatic wait_done(input int lim, output logic seen);
    seen = 1'b0;
    repeat (lim)
    begin
      @(posedge mclk);
      #1;
      if (pass_done === 1'b1)
        seen = 1'b1;
      if (seen)
        break;
    end
  endtask
  // Expected entries and next references follow the slot model
  task automatic check_table();
    logic [15:0] nx [4];
    logic [31:0] e, m;
    logic [1:0] tp;
    logic stop;
    for (int t = 0; t < 4; t++)
      nx[t] = 16'h0001;
    stop = 1'b0;
    for (int s = 0; s < 8; s++)
    begin
      apb(1'b1 ^ 1'b1, `IOAC_OFS_SLOT_TBL + 12'(4 * s), 32'h0);
      stop = stop | !m_pres[s];
      tp = m_type[2*s +: 2];
      e = {2'h0, 1'b0, tp[1] ? `IOAC_RANGE_0_20MA : 2'h0, tp[1], 1'b0, 1'b1, nx[tp],
           m_pts[5*s +: 5], tp, 1'b1};
      m = tp[1] ? 32'h3FFFFFFF : 32'h23FFFFFF;
      if (stop)
        check("slot_valid", q & 32'h1, 32'h0);
      else
      begin
        check("slot_entry", q & m, e);
        nx[tp] = nx[tp] + 16'(m_pts[5*s +: 5]);
      end
    end
    for (int t = 0; t < 4; t++)
    begin
      apb(1'b0, `IOAC_OFS_NEXT_REF + 12'(4 * t), 32'h0);
      check("next_ref", q & 32'hFFFF, {16'h0, nx[t]});
    end
  endtask
  logic seen;
  initial
  begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    apb(1'b0, `IOAC_OFS_CTRL, 32'h0);
    check("ctrl", q & 32'h3, 32'h1);
    wait_done(3000, seen);
    check("done", {31'h0, seen}, 32'h1);
    check_table();
    apb(1'b0, `IOAC_OFS_AI_SCALE, 32'h0);
    check("ai_scale", q, 32'h4E200000);
    apb(1'b0, `IOAC_OFS_FAULT, 32'h0);
    check("fault_add", q & 32'h1, 32'h1);
    apb(1'b1, `IOAC_OFS_FAULT, 32'hF);
    // Slow answers, an empty slot with a module behind it
    dly <= 4'h5;
    m_pres[3] <= 1'b0;
    apb(1'b1, `IOAC_OFS_CMD, 32'h1);
    check("auto_off", {31'h0, confirm_req}, 32'h0);
    apb(1'b1, `IOAC_OFS_CMD, 32'h1);
    check("confirm", {31'h0, confirm_req}, 32'h1);
    check("no_pass", {31'h0, slot_req}, 32'h0);
    apb(1'b1, `IOAC_OFS_CMD, 32'h2);
    wait_done(3000, seen);
    check("done2", {31'h0, seen}, 32'h1);
    check_table();
    apb(1'b0, `IOAC_OFS_FAULT, 32'h0);
    check("fault_extra", q & 32'h8, 32'h8);
    // Cancel: confirmation withdrawn, no pass
    apb(1'b1, `IOAC_OFS_CMD, 32'h1);
    apb(1'b1, `IOAC_OFS_CMD, 32'h1);
    apb(1'b1, `IOAC_OFS_CMD, 32'h4);
    check("cancel", {31'h0, confirm_req}, 32'h0);
    wait_done(200, seen);
    check("no_done", {31'h0, seen}, 32'h0);
    // Manual slot entry clears automatic enable
    apb(1'b1, `IOAC_OFS_MAN_SLOT, 32'h6);
    apb(1'b1, `IOAC_OFS_MAN_DATA, 32'h01000235);
    apb(1'b1, `IOAC_OFS_CMD, 32'h8);
    apb(1'b0, `IOAC_OFS_SLOT_TBL + 12'h018, 32'h0);
    check("manual", q, 32'h01000235);
    apb(1'b0, `IOAC_OFS_CTRL, 32'h0);
    check("auto_clr", q & 32'h3, 32'h0);
    // Protection refuses manual changes, toggles and a confirmed pass
    apb(1'b1, `IOAC_OFS_CMD, 32'h1);
    apb(1'b1, `IOAC_OFS_CTRL, 32'h3);
    apb(1'b1, `IOAC_OFS_MAN_DATA, 32'h0000001B);
    apb(1'b1, `IOAC_OFS_CMD, 32'h8);
    apb(1'b1, `IOAC_OFS_CMD, 32'h1);
    apb(1'b1, `IOAC_OFS_CMD, 32'h2);
    wait_done(3, seen);
    check("prot_done", {31'h0, seen}, 32'h1);
    check("prot_pass", {31'h0, slot_req}, 32'h0);
    apb(1'b0, `IOAC_OFS_SLOT_TBL + 12'h018, 32'h0);
    check("prot_man", q, 32'h01000235);
    apb(1'b0, `IOAC_OFS_CTRL, 32'h0);
    check("prot_tog", q & 32'h3, 32'h3);
    check("prot_req", {31'h0, confirm_req}, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    check("unmapped", {31'h0, last_err}, 32'h1);
    close_out();
  end
endmodule
bind ioac_autoconfig ioac_properties u_props (.mclk(mclk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .slot_req(slot_req), .slot_sel(slot_sel),
  .slot_ack(slot_ack), .slot_present(slot_present), .slot_type(slot_type),
  .slot_points(slot_points), .pass_done(pass_done), .confirm_req(confirm_req));
`default_nettype wire
